// >>> pkg/hrtl_pkg.sv
// constants, types and hex helpers for the record transfer host
// assumes ASCII characters over an 8-bit character stream
package hrtl_pkg;
  // record characters and replies
  localparam logic [7:0] CH_SLASH    = 8'h2F;
  localparam logic [7:0] CH_CR       = 8'h0D;
  localparam logic [7:0] CH_ZERO     = 8'h30;
  localparam logic [7:0] CH_SEVEN    = 8'h37;
  localparam logic [7:0] CH_NINE     = 8'h39;
  localparam logic [7:0] CH_ERR_TEXT = 8'h45;
  // limits
  localparam int          MAX_DATA        = 30;
  localparam int          MAX_TRIES       = 10;
  localparam int          BUF_DEPTH       = 32;
  localparam int          SYNC_STAGES     = 3;
  localparam logic [15:0] LOAD_ADDR_FLOOR = 16'h4500;
  // character positions inside a record, and record lengths
  localparam logic [6:0] POS_ADDR_LAST  = 7'h04;
  localparam logic [6:0] POS_CNT_LAST   = 7'h06;
  localparam logic [6:0] POS_HSUM_LAST  = 7'h08;
  localparam logic [6:0] POS_DATA_FIRST = 7'h09;
  localparam logic [6:0] END_ESUM_LAST  = 7'h0A;
  localparam logic [6:0] DATA_OVERHEAD  = 7'h0C;
  localparam logic [6:0] END_LEN        = 7'h0C;
  localparam logic [6:0] ERR_LEN        = 7'h04;
  // failure codes
  localparam logic [2:0] FAIL_NONE  = 3'h0;
  localparam logic [2:0] FAIL_RANGE = 3'h1;
  localparam logic [2:0] FAIL_RETRY = 3'h2;
  localparam logic [2:0] FAIL_DEV   = 3'h3;
  localparam logic [2:0] FAIL_USER  = 3'h4;
  localparam logic [2:0] FAIL_FILE  = 3'h5;

  typedef enum logic [1:0] {K_DATA, K_END, K_ERR, K_REPLY} hrtl_kind_t;
  typedef enum logic [1:0] {TX_IDLE, TX_FETCH, TX_LOAD, TX_HOLD}
    hrtl_tx_state_t;
  typedef enum logic [2:0] {M_IDLE, M_TX, M_WAIT, M_RX, M_HOLD}
    hrtl_main_state_t;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    return (c >= 8'h41) ? c[3:0] + 4'h9 : c[3:0];
  endfunction

  function automatic logic is_hex(input logic [7:0] c);
    return (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46);
  endfunction

  function automatic logic [7:0] nsum(input logic [15:0] v);
    return 8'({4'h0, v[15:12]} + {4'h0, v[11:8]} + {4'h0, v[7:4]}
              + {4'h0, v[3:0]});
  endfunction

  function automatic logic [3:0] nib16(input logic [15:0] v,
                                       input logic [1:0]  i);
    case (i)
      2'h0:    return v[15:12];
      2'h1:    return v[11:8];
      2'h2:    return v[7:4];
      default: return v[3:0];
    endcase
  endfunction
endpackage

// >>> verilog/hrtl_sync.sv
// three-stage synchroniser for an asynchronous level input
// assumes one clock; output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module hrtl_sync (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  // level
  input  wire logic d_i,
  output var  logic q_o
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1  <= 1'b0;
      s2  <= 1'b0;
      s3  <= 1'b0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule
`default_nettype wire

// >>> verilog/hrtl_mem.sv
// record payload buffer, one write and one registered read port
// assumes writer and reader never use the same word in one cycle
`timescale 1ns/1ps
`default_nettype none
module hrtl_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // write port
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    waddr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  // read port
  input  wire logic [AW-1:0]    raddr_i,
  output var  logic [WIDTH-1:0] rdata_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

// >>> verilog/hrtl_host.sv
// host end of the hex record link: loads records into the board,
// receives records sent by the board, checks sums and replies.
// assumes a character stream on the same clock, escape key on a pin.
`timescale 1ns/1ps
`default_nettype none
module hrtl_host
  import hrtl_pkg::*;
#(
  parameter int MAX_DATA_P  = MAX_DATA,
  parameter int MAX_TRIES_P = MAX_TRIES
) (
  // clock, reset, enable
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_I,
  input  wire logic        CLK_EN_I,
  // user commands
  input  wire logic        LOAD_GO_I,
  input  wire logic        LOAD_END_I,
  input  wire logic        RECV_GO_I,
  input  wire logic [15:0] LOAD_ADDR_I,
  input  wire logic [4:0]  LOAD_COUNT_I,
  input  wire logic [15:0] ENTRY_I,
  input  wire logic        FILE_ERR_I,
  input  wire logic        REC_TAKEN_I,
  input  wire logic        ABORT_PIN_I,
  // user buffer access
  input  wire logic        USR_WE_I,
  input  wire logic [4:0]  USR_WADDR_I,
  input  wire logic [7:0]  USR_WDATA_I,
  input  wire logic [4:0]  USR_RADDR_I,
  output var  logic [7:0]  USR_RDATA_O,
  // character link
  input  wire logic [7:0]  RX_DATA_I,
  input  wire logic        RX_VALID_I,
  input  wire logic        TX_READY_I,
  output var  logic [7:0]  TX_DATA_O,
  output var  logic        TX_VALID_O,
  // status
  output var  logic        BUSY_O,
  output var  logic        DONE_O,
  output var  logic        FAIL_O,
  output var  logic [2:0]  FAIL_CODE_O,
  output var  logic [3:0]  TRIES_O,
  output var  logic        REC_VALID_O,
  output var  logic [15:0] REC_ADDR_O,
  output var  logic [7:0]  REC_COUNT_O,
  output var  logic [15:0] ENTRY_O
);
  hrtl_main_state_t m_state;
  hrtl_main_state_t m_ret;
  hrtl_tx_state_t   tx_state;
  hrtl_kind_t       kind;
  logic [7:0]  reply_char;
  logic [2:0]  fin;
  logic        tx_go;
  logic        tx_done;
  logic [15:0] cur_addr;
  logic [4:0]  cur_cnt;
  logic [6:0]  tx_pos;
  logic [6:0]  tx_len;
  logic [6:0]  tx_k;
  logic [7:0]  psum_tx;
  logic [7:0]  hsum_tx;
  logic [15:0] esum_tx;
  logic [7:0]  next_char;
  logic [3:0]  nib;
  logic        is_nib;
  logic        data_nib;
  logic [7:0]  mem_rdata;
  logic        abort_sync;
  logic [6:0]  rx_pos;
  logic [6:0]  rx_k;
  logic [6:0]  rx_exp_cr;
  logic [15:0] rx_sh;
  logic [15:0] rx_addr;
  logic [7:0]  rx_cnt;
  logic [7:0]  hcalc;
  logic [7:0]  pcalc;
  logic [3:0]  nv;
  logic        rx_bad;
  logic        rx_err_rec;
  logic        rec_end;
  logic        rec_good;
  logic        rx_we;

  hrtl_sync u_abort_sync (
    .clk_i (CORE_CLK_I),
    .rst_i (RST_I),
    .ce_i  (CLK_EN_I),
    .d_i   (ABORT_PIN_I),
    .q_o   (abort_sync)
  );

  // buffer shared: receiver writes while receiving, the user only while idle
  hrtl_mem #(.WIDTH(8), .DEPTH(BUF_DEPTH), .AW(5)) u_buf (
    .clk_i   (CORE_CLK_I),
    .rst_i   (RST_I),
    .ce_i    (CLK_EN_I),
    .we_i    (rx_we || (m_state == M_IDLE && USR_WE_I)),
    .waddr_i (rx_we ? 5'(rx_k[5:1]) : USR_WADDR_I),
    .wdata_i (rx_we ? {rx_sh[3:0], nv} : USR_WDATA_I),
    .raddr_i ((tx_state != TX_IDLE) ? 5'(tx_k[5:1]) : USR_RADDR_I),
    .rdata_o (mem_rdata)
  );
  assign USR_RDATA_O = mem_rdata;

  // transmit side: character for the current position
  always_comb begin
    hsum_tx = 8'(nsum(cur_addr) + {7'h00, cur_cnt[4]} + {4'h0, cur_cnt[3:0]});
    esum_tx = {8'h00, nsum(cur_addr)};
    tx_k = tx_pos - POS_DATA_FIRST;
    nib = 4'h0;
    is_nib = 1'b0;
    data_nib = 1'b0;
    next_char = CH_CR;
    case (kind)
      K_REPLY: next_char = reply_char;
      K_ERR: begin
        if (tx_pos == 7'h02) next_char = CH_ERR_TEXT;
        else if (tx_pos != ERR_LEN - 7'h01) next_char = CH_SLASH;
      end
      default: begin
        is_nib = 1'b1;
        if (tx_pos == 7'h00) begin
          is_nib = 1'b0;
          next_char = CH_SLASH;
        end else if (tx_pos <= POS_ADDR_LAST) begin
          nib = nib16(cur_addr, 2'(tx_pos - 7'h01));
        end else if (kind == K_END) begin
          if (tx_pos <= POS_CNT_LAST) nib = 4'h0;
          else if (tx_pos <= END_ESUM_LAST)
            nib = nib16(esum_tx, 2'(tx_pos - 7'h07));
          else is_nib = 1'b0;
        end else if (tx_pos == 7'h05) nib = {3'h0, cur_cnt[4]};
        else if (tx_pos == 7'h06) nib = cur_cnt[3:0];
        else if (tx_pos == 7'h07) nib = hsum_tx[7:4];
        else if (tx_pos == POS_HSUM_LAST) nib = hsum_tx[3:0];
        else if (tx_pos < tx_len - 7'h03) begin
          nib = tx_k[0] ? mem_rdata[3:0] : mem_rdata[7:4];
          data_nib = 1'b1;
        end else if (tx_pos == tx_len - 7'h03) nib = psum_tx[7:4];
        else if (tx_pos == tx_len - 7'h02) nib = psum_tx[3:0];
        else is_nib = 1'b0;
        if (is_nib) next_char = hex_char(nib);
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      tx_state   <= TX_IDLE;
      tx_pos     <= 7'h00;
      psum_tx    <= 8'h00;
      tx_done    <= 1'b0;
      TX_DATA_O  <= 8'h00;
      TX_VALID_O <= 1'b0;
    end else if (CLK_EN_I) begin
      tx_done <= 1'b0;
      case (tx_state)
        TX_IDLE: if (tx_go) begin
          tx_pos   <= 7'h00;
          psum_tx  <= 8'h00;
          tx_state <= TX_FETCH;
        end
        // buffer read is registered, so wait one cycle for its data
        TX_FETCH: tx_state <= TX_LOAD;
        TX_LOAD: begin
          TX_DATA_O  <= next_char;
          TX_VALID_O <= 1'b1;
          if (data_nib) psum_tx <= psum_tx + {4'h0, nib};
          tx_state <= TX_HOLD;
        end
        TX_HOLD: if (TX_READY_I) begin
          TX_VALID_O <= 1'b0;
          if (tx_pos == tx_len - 7'h01) begin
            tx_done  <= 1'b1;
            tx_state <= TX_IDLE;
          end else begin
            tx_pos   <= tx_pos + 7'h01;
            tx_state <= TX_FETCH;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  always_comb begin
    case (kind)
      K_REPLY: tx_len = 7'h01;
      K_ERR:   tx_len = ERR_LEN;
      K_END:   tx_len = END_LEN;
      default: tx_len = DATA_OVERHEAD + {1'b0, cur_cnt, 1'b0};
    endcase
  end

  // receive side decode
  always_comb begin
    nv = hex_val(RX_DATA_I);
    rx_k = rx_pos - POS_DATA_FIRST;
    rx_exp_cr = (rx_cnt == 8'h00) ? END_LEN - 7'h01
              : 7'(DATA_OVERHEAD - 7'h01 + {rx_cnt[5:0], 1'b0});
    rec_end = RX_VALID_I && m_state == M_RX && rx_pos != 7'h00
              && RX_DATA_I == CH_CR;
    rec_good = !rx_bad && rx_pos == rx_exp_cr;
    rx_we = RX_VALID_I && m_state == M_RX && !rx_err_rec && !rx_bad
            && is_hex(RX_DATA_I) && rx_cnt != 8'h00
            && rx_pos > POS_HSUM_LAST && rx_pos < rx_exp_cr - 7'h02
            && rx_k[0];
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rx_pos     <= 7'h00;
      rx_sh      <= 16'h0000;
      rx_addr    <= 16'h0000;
      rx_cnt     <= 8'h00;
      hcalc      <= 8'h00;
      pcalc      <= 8'h00;
      rx_bad     <= 1'b0;
      rx_err_rec <= 1'b0;
    end else if (CLK_EN_I) begin
      if (m_state != M_RX) begin
        rx_pos <= 7'h00;
      end else if (RX_VALID_I) begin
        if (rx_pos == 7'h00) begin
          // stray characters between records are skipped
          if (RX_DATA_I == CH_SLASH) begin
            rx_pos     <= 7'h01;
            rx_bad     <= 1'b0;
            rx_err_rec <= 1'b0;
            rx_cnt     <= 8'h00;
            hcalc      <= 8'h00;
            pcalc      <= 8'h00;
          end
        end else if (RX_DATA_I == CH_CR) begin
          rx_pos <= 7'h00;
        end else begin
          if (rx_pos != 7'h7F) rx_pos <= rx_pos + 7'h01;
          if (rx_pos == 7'h01 && RX_DATA_I == CH_SLASH) begin
            rx_err_rec <= 1'b1;
          end else if (!rx_err_rec) begin
            if (!is_hex(RX_DATA_I) || rx_pos >= rx_exp_cr)
              rx_bad <= 1'b1;
            rx_sh <= {rx_sh[11:0], nv};
            if (rx_pos <= POS_CNT_LAST) hcalc <= hcalc + {4'h0, nv};
            if (rx_pos == POS_ADDR_LAST) rx_addr <= {rx_sh[11:0], nv};
            if (rx_pos == POS_CNT_LAST) begin
              rx_cnt <= {rx_sh[3:0], nv};
              if ({rx_sh[3:0], nv} > 8'(MAX_DATA_P)) rx_bad <= 1'b1;
            end
            if (rx_cnt == 8'h00) begin
              if (rx_pos == END_ESUM_LAST
                  && {rx_sh[11:0], nv} != {8'h00, nsum(rx_addr)})
                rx_bad <= 1'b1;
            end else begin
              if (rx_pos == POS_HSUM_LAST && {rx_sh[3:0], nv} != hcalc)
                rx_bad <= 1'b1;
              if (rx_pos > POS_HSUM_LAST && rx_pos < rx_exp_cr - 7'h02)
                pcalc <= pcalc + {4'h0, nv};
              if (rx_pos == rx_exp_cr - 7'h01
                  && {rx_sh[3:0], nv} != pcalc)
                rx_bad <= 1'b1;
            end
          end
        end
      end
    end
  end

  // transfer control
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      m_state     <= M_IDLE;
      m_ret       <= M_IDLE;
      kind        <= K_REPLY;
      reply_char  <= CH_ZERO;
      fin         <= FAIL_NONE;
      tx_go       <= 1'b0;
      cur_addr    <= 16'h0000;
      cur_cnt     <= 5'h00;
      TRIES_O     <= 4'h0;
      DONE_O      <= 1'b0;
      FAIL_O      <= 1'b0;
      FAIL_CODE_O <= FAIL_NONE;
      BUSY_O      <= 1'b0;
      REC_VALID_O <= 1'b0;
      REC_ADDR_O  <= 16'h0000;
      REC_COUNT_O <= 8'h00;
      ENTRY_O     <= 16'h0000;
    end else if (CLK_EN_I) begin
      tx_go       <= 1'b0;
      DONE_O      <= 1'b0;
      FAIL_O      <= 1'b0;
      REC_VALID_O <= 1'b0;
      BUSY_O      <= m_state != M_IDLE;
      case (m_state)
        M_IDLE: begin
          fin <= FAIL_NONE;
          if (LOAD_GO_I) begin
            if (LOAD_ADDR_I <= LOAD_ADDR_FLOOR || LOAD_COUNT_I == 5'h00
                || LOAD_COUNT_I > 5'(MAX_DATA_P)) begin
              FAIL_O      <= 1'b1;
              FAIL_CODE_O <= FAIL_RANGE;
            end else begin
              cur_addr <= LOAD_ADDR_I;
              cur_cnt  <= LOAD_COUNT_I;
              kind     <= K_DATA;
              TRIES_O  <= 4'h0;
              tx_go    <= 1'b1;
              m_ret    <= M_WAIT;
              m_state  <= M_TX;
            end
          end else if (LOAD_END_I) begin
            cur_addr <= ENTRY_I;
            cur_cnt  <= 5'h00;
            kind     <= K_END;
            TRIES_O  <= 4'h0;
            tx_go    <= 1'b1;
            m_ret    <= M_WAIT;
            m_state  <= M_TX;
          end else if (RECV_GO_I) begin
            kind       <= K_REPLY;
            reply_char <= FILE_ERR_I ? CH_NINE : CH_ZERO;
            fin        <= FILE_ERR_I ? FAIL_FILE : FAIL_NONE;
            m_ret      <= FILE_ERR_I ? M_IDLE : M_RX;
            TRIES_O    <= 4'h0;
            tx_go      <= 1'b1;
            m_state    <= M_TX;
          end
        end
        M_TX: if (tx_done) begin
          m_state <= m_ret;
          if (m_ret == M_IDLE) begin
            DONE_O      <= fin == FAIL_NONE;
            FAIL_O      <= fin != FAIL_NONE;
            FAIL_CODE_O <= fin;
          end
        end
        M_WAIT: begin
          if (abort_sync) begin
            kind    <= K_ERR;
            fin     <= FAIL_USER;
            tx_go   <= 1'b1;
            m_ret   <= M_IDLE;
            m_state <= M_TX;
          end else if (RX_VALID_I) begin
            case (RX_DATA_I)
              CH_ZERO: begin
                DONE_O  <= 1'b1;
                m_state <= M_IDLE;
              end
              CH_SEVEN: begin
                TRIES_O <= TRIES_O + 4'h1;
                tx_go   <= 1'b1;
                m_state <= M_TX;
                if (TRIES_O == 4'(MAX_TRIES_P - 1)) begin
                  kind  <= K_ERR;
                  fin   <= FAIL_RETRY;
                  m_ret <= M_IDLE;
                end
              end
              CH_NINE: begin
                FAIL_O      <= 1'b1;
                FAIL_CODE_O <= FAIL_DEV;
                m_state     <= M_IDLE;
              end
              default: ;
            endcase
          end
        end
        M_RX: begin
          if (abort_sync) begin
            kind       <= K_REPLY;
            reply_char <= CH_NINE;
            fin        <= FAIL_USER;
            tx_go      <= 1'b1;
            m_ret      <= M_IDLE;
            m_state    <= M_TX;
          end else if (rec_end) begin
            if (rx_err_rec) begin
              FAIL_O      <= 1'b1;
              FAIL_CODE_O <= FAIL_DEV;
              m_state     <= M_IDLE;
            end else if (!rec_good) begin
              kind       <= K_REPLY;
              reply_char <= CH_SEVEN;
              if (TRIES_O != 4'hF) TRIES_O <= TRIES_O + 4'h1;
              tx_go      <= 1'b1;
              m_ret      <= M_RX;
              m_state    <= M_TX;
            end else if (rx_cnt == 8'h00) begin
              ENTRY_O    <= rx_addr;
              kind       <= K_REPLY;
              reply_char <= CH_ZERO;
              tx_go      <= 1'b1;
              m_ret      <= M_IDLE;
              m_state    <= M_TX;
            end else begin
              REC_VALID_O <= 1'b1;
              REC_ADDR_O  <= rx_addr;
              REC_COUNT_O <= rx_cnt;
              TRIES_O     <= 4'h0;
              m_state     <= M_HOLD;
            end
          end
        end
        // the ack waits for the user, holding the board back
        M_HOLD: if (REC_TAKEN_I) begin
          kind       <= K_REPLY;
          reply_char <= FILE_ERR_I ? CH_NINE : CH_ZERO;
          fin        <= FILE_ERR_I ? FAIL_FILE : FAIL_NONE;
          m_ret      <= FILE_ERR_I ? M_IDLE : M_RX;
          tx_go      <= 1'b1;
          m_state    <= M_TX;
        end
        default: m_state <= M_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I || !CLK_EN_I);

  AST_OPEN_SLASH: assert property (
    TX_VALID_O && tx_pos == 7'h00 && kind != K_REPLY
    |-> TX_DATA_O == CH_SLASH) else $error("record must open with slash");
  AST_CLOSE_CR: assert property (
    TX_VALID_O && kind != K_REPLY && tx_pos == tx_len - 7'h01
    |-> TX_DATA_O == CH_CR) else $error("record must close with CR");
  AST_DATA_MAX: assert property (
    m_state == M_TX && kind == K_DATA
    |-> cur_cnt != 5'h00 && cur_cnt <= 5'(MAX_DATA_P))
    else $error("data record count out of range");
  AST_LEN_COUNT: assert property (
    TX_VALID_O && kind == K_DATA && TX_DATA_O == CH_CR
    |-> tx_pos == DATA_OVERHEAD - 7'h01 + {1'b0, cur_cnt, 1'b0})
    else $error("record length does not match count");
  AST_HSUM_LO: assert property (
    TX_VALID_O && kind == K_DATA && tx_pos == POS_HSUM_LAST
    |-> hex_val(TX_DATA_O) == hsum_tx[3:0])
    else $error("header sum wrong");
  AST_END_ZERO: assert property (
    TX_VALID_O && kind == K_END && (tx_pos == 7'h05 || tx_pos == 7'h06)
    |-> TX_DATA_O == CH_ZERO) else $error("final count must be 00");
  AST_ENTRY_SUM: assert property (
    TX_VALID_O && kind == K_END && tx_pos == END_ESUM_LAST
    |-> hex_val(TX_DATA_O) == esum_tx[3:0])
    else $error("entry sum wrong");
  AST_RETRY_CAP: assert property (
    m_state == M_WAIT && !abort_sync && RX_VALID_I
    && RX_DATA_I == CH_SEVEN && TRIES_O == 4'(MAX_TRIES_P - 1)
    |=> kind == K_ERR && fin == FAIL_RETRY && m_state == M_TX)
    else $error("load not abandoned after last retry");
  AST_FLOOR: assert property (
    m_state == M_TX && kind == K_DATA |-> cur_addr > LOAD_ADDR_FLOOR)
    else $error("load address in reserved area");
  AST_NAK_BAD: assert property (
    rec_end && !abort_sync && !rx_err_rec && !rec_good
    |-> ##4 (TX_VALID_O && TX_DATA_O == CH_SEVEN))
    else $error("bad record not refused");
  AST_FILE_REFUSE: assert property (
    m_state == M_HOLD && REC_TAKEN_I && FILE_ERR_I
    |-> ##4 (TX_VALID_O && TX_DATA_O == CH_NINE))
    else $error("file error not answered with 9");
  AST_HEX_UPPER: assert property (
    TX_VALID_O && kind inside {K_DATA, K_END} && tx_pos != 7'h00
    && tx_pos != tx_len - 7'h01 |-> is_hex(TX_DATA_O))
    else $error("record character not upper-case hex");
endmodule
`default_nettype wire

// >>> tb/hrtl_board_model.sv
// board side of the record link: collects host characters, answers
// each record ending in CR with the reply character, sends records
`timescale 1ns/1ps
`default_nettype none
module hrtl_board_model
  import hrtl_pkg::*;
(
  // clock and behaviour
  input  wire logic       clk_i,
  input  wire logic [7:0] reply_i,
  // host to board
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output var  logic       tx_ready_o,
  // board to host
  output var  logic [7:0] rx_data_o,
  output var  logic       rx_valid_o
);
  logic [7:0] q[$];
  logic       pend = 1'b0;
  initial begin
    tx_ready_o = 1'b0;
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
  end
  // ready every other cycle, so the host must hold its character
  always @(posedge clk_i) begin
    tx_ready_o <= ~tx_ready_o;
    if (tx_valid_i && tx_ready_o) q.push_back(tx_data_i);
    pend <= tx_valid_i && tx_ready_o && tx_data_i == CH_CR;
  end
  // line does not keep the last character once a pulse is over
  task automatic send_ch(input logic [7:0] c);
    @(negedge clk_i);
    rx_data_o  = c;
    rx_valid_o = 1'b1;
    @(negedge clk_i);
    rx_valid_o = 1'b0;
    rx_data_o  = ~c;
  endtask
  task automatic send(input string s);
    foreach (s[i]) send_ch(s[i]);
  endtask
  // reply only after a whole record, never mid-record
  always @(posedge clk_i) if (pend) send_ch(reply_i);
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the host end of the record link
// assumes the board model answers in place of the real board
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import hrtl_pkg::*;
  logic        clk = 0, rst = 1, go = 0, rgo = 0, taken = 0;
  logic        lend = 0, ferr = 0;
  logic        we = 0, done, fail, recv, fin, rxv, rdy, txv;
  logic [15:0] addr = 16'h4501, ent = 16'h0000, raddr, entry;
  logic [7:0]  wdat = 8'hA5, rd, rxd, txd, rcnt, rep = CH_ZERO;
  logic [4:0]  cnt = 5'h01, wa = 5'h00;
  logic [2:0]  code;
  logic [3:0]  tries;
  int          n_fail = 0, samples_checked = 0;
  always #25 clk = ~clk;
  always_comb fin = done | fail;
  hrtl_host #(.MAX_TRIES_P(3)) i_dut (
    .CORE_CLK_I(clk), .RST_I(rst), .CLK_EN_I(1'b1), .LOAD_GO_I(go),
    .LOAD_END_I(lend), .RECV_GO_I(rgo), .LOAD_ADDR_I(addr),
    .LOAD_COUNT_I(cnt), .ENTRY_I(ent), .FILE_ERR_I(ferr),
    .REC_TAKEN_I(taken), .ABORT_PIN_I(1'b0), .USR_WE_I(we),
    .USR_WADDR_I(wa), .USR_WDATA_I(wdat), .USR_RADDR_I(5'h00),
    .USR_RDATA_O(rd), .RX_DATA_I(rxd), .RX_VALID_I(rxv), .TX_READY_I(rdy),
    .TX_DATA_O(txd), .TX_VALID_O(txv), .BUSY_O(), .DONE_O(done),
    .FAIL_O(fail), .FAIL_CODE_O(code), .TRIES_O(tries),
    .REC_VALID_O(recv), .REC_ADDR_O(raddr), .REC_COUNT_O(rcnt),
    .ENTRY_O(entry));
  hrtl_board_model i_brd (.clk_i(clk), .reply_i(rep), .tx_data_i(txd),
    .tx_valid_i(txv), .tx_ready_o(rdy), .rx_data_o(rxd), .rx_valid_o(rxv));
  task finish_test;
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task chk_rec(input string s);
    chk(16'(i_brd.q.size()), 16'(s.len()));
    for (int i = 0; i < s.len(); i++) chk(16'(i_brd.q[i]), 16'(s[i]));
  endtask
  // bounded waits; running out counts as a mismatch and ends the run
  task automatic wait_hi(ref logic s);
    int i;
    for (i = 0; i < 3000 && s !== 1'b1; i++) @(negedge clk);
    if (i == 3000) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic wait_q(input int n);
    int i;
    for (i = 0; i < 3000 && i_brd.q.size() < n; i++) @(negedge clk);
    if (i == 3000) begin
      n_fail++;
      finish_test();
    end
  endtask
  task start(input logic [15:0] a);
    i_brd.q.delete();
    addr = a;
    go   = 1'b1;
    @(negedge clk);
    go   = 1'b0;
    wait_hi(fin);
  endtask
  task t_load;
    we = 1'b1;
    @(negedge clk);
    we = 1'b0;
    start(16'h4501);
    chk(16'(done), 16'h0001);
    chk_rec("/4501010BA50F\r");
    $display("load record done");
  endtask
  task t_range;
    start(16'h4500);
    chk(16'(fail), 16'h0001);
    chk(16'(code), 16'(FAIL_RANGE));
    $display("range refusal done");
  endtask
  task t_retry;
    rep = CH_SEVEN;
    start(16'h4501);
    rep = CH_ZERO;
    chk(16'(code), 16'(FAIL_RETRY));
    chk(16'(tries), 16'h0003);
    chk_rec({{3{"/4501010BA50F\r"}}, "//E\r"});
    $display("retry limit done");
  endtask
  task t_end;
    i_brd.q.delete();
    ent  = 16'hABCD;
    rep  = CH_NINE;
    lend = 1'b1;
    @(negedge clk);
    lend = 1'b0;
    wait_hi(fin);
    rep  = CH_ZERO;
    chk(16'(code), 16'(FAIL_DEV));
    chk_rec("/ABCD00002E\r");
    $display("final record done");
  endtask
  task recv_open;
    i_brd.q.delete();
    rgo = 1'b1;
    @(negedge clk);
    rgo = 1'b0;
    wait_q(1);
  endtask
  task t_recv;
    recv_open();
    i_brd.send("/4501010C3C0F\r");
    wait_q(2);
    i_brd.send("/4501010B3C0F\r");
    wait_hi(recv);
    chk(raddr, 16'h4501);
    chk(16'(rcnt), 16'h0001);
    taken = 1'b1;
    @(negedge clk);
    taken = 1'b0;
    wait_q(3);
    i_brd.send("/ABCD00002E\r");
    wait_hi(fin);
    chk(16'(done), 16'h0001);
    chk(entry, 16'hABCD);
    chk(16'(rd), 16'h003C);
    chk_rec("0700");
    $display("receive done");
  endtask
  task t_ferr;
    recv_open();
    i_brd.send("/4501010B1E0F\r");
    wait_hi(recv);
    ferr  = 1'b1;
    taken = 1'b1;
    @(negedge clk);
    ferr  = 1'b0;
    taken = 1'b0;
    wait_hi(fin);
    chk(16'(code), 16'(FAIL_FILE));
    chk(16'(rd), 16'h001E);
    chk_rec("09");
    $display("file refusal done");
  endtask
  task t_dev;
    recv_open();
    i_brd.send("//E\r");
    wait_hi(fin);
    chk(16'(code), 16'(FAIL_DEV));
    chk_rec("0");
    $display("board abort done");
  endtask
  task t_zero;
    recv_open();
    i_brd.send("/0000000000\r");
    wait_hi(fin);
    chk(16'(done), 16'h0001);
    chk(entry, 16'h0000);
    chk_rec("00");
    $display("zero entry done");
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    t_load();
    t_range();
    t_retry();
    t_end();
    t_recv();
    t_ferr();
    t_dev();
    t_zero();
    finish_test();
  end
endmodule
`default_nettype wire
